// File: core/pscr_pkg.sv
// package: offsets, field positions, reset values and types of the port phy status/control bank
package pscr_pkg;
   // =====================================================================
   // register offsets on the switch register port
   // =====================================================================
   localparam logic [7:0] P1_STAT1_OFS = 8'h2E; // port 1 status 1, partner ability
   localparam logic [7:0] P1_STAT2_OFS = 8'h2F; // port 1 phy status/control
   localparam logic [7:0] P2_STAT1_OFS = 8'h3E; // port 2 status 1, partner ability
   localparam logic [7:0] P2_STAT2_OFS = 8'h3F; // port 2 phy status/control
   localparam logic [7:0] P3_STAT2_OFS = 8'h4F; // port 3, no integrated phy
   localparam logic [7:0] P4_STAT2_OFS = 8'h5F; // port 4, no integrated phy

   // =====================================================================
   // field positions of the status/control register
   // =====================================================================
   localparam int LOOP_BIT = 7;   // phy loopback
   localparam int RSV_BIT = 6;    // reserved, reads zero
   localparam int ISO_BIT = 5;    // phy isolate
   localparam int SRST_BIT = 4;   // soft reset, self clearing
   localparam int FLINK_BIT = 3;  // force link
   localparam int OPM_LSB = 0;    // operation mode field, 3 bits
   localparam int PART_W = 5;     // partner ability width, bits 4..0

   // =====================================================================
   // reset values
   // =====================================================================
   localparam logic [7:0] STAT2_RST = 8'h01;   // whole register after reset
   localparam logic [2:0] OPM_RST = 3'h1;      // auto-negotiation in progress
   localparam logic [7:0] NOPHY_READ = 8'h01;  // ports 3/4: only bit 0 visible

   // =====================================================================
   // management (mdc/mdio) standard register numbers and bit positions
   // =====================================================================
   localparam logic [4:0] MII_BMCR = 5'h00;   // basic control
   localparam logic [4:0] MII_BMSR = 5'h01;   // basic status
   localparam logic [4:0] MII_ANLPAR = 5'h05; // link partner ability
   localparam int BMCR_RST_BIT = 15;
   localparam int BMCR_LOOP_BIT = 14;
   localparam int BMCR_ISO_BIT = 10;
   localparam int BMSR_LINK_BIT = 2;
   localparam int BMSR_ANC_BIT = 5;
   localparam int ANLPAR_10HD_BIT = 5;        // partner bits 0..3 map to 5..8
   localparam int ANLPAR_PAUSE_BIT = 10;

   // =====================================================================
   // operation mode codes
   // =====================================================================
   typedef enum logic [2:0] {
      OPM_AN = 3'b001,
      OPM_10HD = 3'b010,
      OPM_100HD = 3'b011,
      OPM_10FD = 3'b101,
      OPM_100FD = 3'b110
   } pscr_opmode_e;

   // =====================================================================
   // soft reset timing
   // =====================================================================
   localparam int CLK_PERIOD_PS = 5000;   // 200 mhz core clock
   localparam int SRST_TIME_NS = 100;     // least phy reset pulse
   localparam int SRST_CYCLES = (SRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] SRST_CNT_ZERO = 8'h00;

   // per-phy control bundle driven into the phy
   typedef struct packed {
      logic loopback;   // pmd/pma loopback
      logic isolate;    // cut from mii and tx line
      logic soft_reset; // reset pulse in progress
      logic force_link; // force link-up
   } pscr_phy_ctrl_s;

   // per-phy status bundle coming from the phy
   typedef struct packed {
      logic [4:0] partner; // flow ctl, 100fd, 100hd, 10fd, 10hd
      logic [2:0] opmode;  // current operation mode
      logic link_up;       // link good
   } pscr_phy_stat_s;
endpackage : pscr_pkg

// File: core/pscr_rst_timer.sv
// self-clearing soft reset pulse generator for one phy
module pscr_rst_timer (
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   input wire logic start_i,  // one-cycle request
   output logic busy_o        // reset in progress
);
   // =====================================================================
   // down counter
   // =====================================================================
   logic [7:0] cnt_q; // cycles left
   logic [7:0] cnt_d;
   wire logic idle = (cnt_q == pscr_pkg::SRST_CNT_ZERO);

   // a request while busy is ignored, so the pulse never stretches forever
   assign cnt_d = (start_i && idle) ? 8'(pscr_pkg::SRST_CYCLES) :
                  idle ? cnt_q : cnt_q - 8'h01;
   assign busy_o = !idle;

   // counter register
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cnt_q <= pscr_pkg::SRST_CNT_ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : pscr_rst_timer

// File: core/pscr_regs.sv
// port phy status/control register bank with management register view
// Function
// - five read-only partner ability bits, reset zero
// - bit 7 loops phy at pmd/pma
// - looped port pairs with other phy port monitor
// - bit 5 isolates phy from mii/tx
// - bit 4 soft reset, clears itself
// - bit 3 forces phy link up
// - read-only 3-bit operation mode, reset 001
// - ports 3/4 bits 7..1 reserved
// - loop, isolate, reset and partner bits also visible through mdc/mdio map
module pscr_regs (
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   // switch register port
   input wire logic [7:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_WDATA_I,
   output logic [7:0] REG_RDATA_O,
   output logic REG_RVALID_O,
   // management register port
   input wire logic MIIM_PHY_I,
   input wire logic [4:0] MIIM_REG_I,
   input wire logic MIIM_WR_I,
   input wire logic MIIM_RD_I,
   input wire logic [15:0] MIIM_WDATA_I,
   output logic [15:0] MIIM_RDATA_O,
   output logic MIIM_RVALID_O,
   // phy side
   input wire pscr_pkg::pscr_phy_stat_s PHY1_STAT_I,
   input wire pscr_pkg::pscr_phy_stat_s PHY2_STAT_I,
   output pscr_pkg::pscr_phy_ctrl_s PHY1_CTRL_O,
   output pscr_pkg::pscr_phy_ctrl_s PHY2_CTRL_O,
   output logic [1:0] PHY1_MONITOR_O,
   output logic [1:0] PHY2_MONITOR_O
);
   // =====================================================================
   // helpers
   // =====================================================================
   // register port hit on a phy port's status/control register
   function automatic logic hit_stat2(input logic [7:0] addr, input logic p);
      hit_stat2 = p ? (addr == pscr_pkg::P2_STAT2_OFS) : (addr == pscr_pkg::P1_STAT2_OFS);
   endfunction : hit_stat2

   // compose the 8-bit status/control view of one phy port
   function automatic logic [7:0] stat2_view(input logic lb, input logic iso,
                                            input logic rst, input logic fl,
                                            input logic [2:0] opm);
      logic [7:0] v;
      v = 8'h00;
      v[pscr_pkg::LOOP_BIT] = lb;
      v[pscr_pkg::ISO_BIT] = iso;
      v[pscr_pkg::SRST_BIT] = rst;
      v[pscr_pkg::FLINK_BIT] = fl;
      v[pscr_pkg::OPM_LSB +: 3] = opm;
      stat2_view = v;
   endfunction : stat2_view

   // =====================================================================
   // per-port state
   // =====================================================================
   pscr_pkg::pscr_phy_stat_s stat [2]; // phy status by port index
   logic [1:0] loop_q, loop_d;        // loopback enables
   logic [1:0] iso_q, iso_d;          // isolate enables
   logic [1:0] flink_q, flink_d;      // force link enables
   logic [2:0] opm_q [2];             // captured operation mode
   logic [2:0] opm_view [2];          // mode as read back, forced during reset
   logic [1:0] srst_start;            // soft reset requests
   logic [1:0] srst_busy;             // soft reset in progress
   logic [1:0] reg_wr_hit;            // register port write per port
   logic [1:0] miim_wr_hit;           // management write to control reg

   assign stat[0] = PHY1_STAT_I;
   assign stat[1] = PHY2_STAT_I;

   // =====================================================================
   // write decode and next-state per phy port
   // =====================================================================
   generate
      for (genvar p = 0; p < 2; p++) begin : g_port
         assign reg_wr_hit[p] = REG_WR_I && hit_stat2(REG_ADDR_I, 1'(p));
         assign miim_wr_hit[p] = MIIM_WR_I && (MIIM_PHY_I == 1'(p)) &&
                                 (MIIM_REG_I == pscr_pkg::MII_BMCR);
         // the register port wins over a same-cycle management write
         assign loop_d[p] = reg_wr_hit[p] ? REG_WDATA_I[pscr_pkg::LOOP_BIT] :
                            miim_wr_hit[p] ? MIIM_WDATA_I[pscr_pkg::BMCR_LOOP_BIT] :
                            loop_q[p];
         assign iso_d[p] = reg_wr_hit[p] ? REG_WDATA_I[pscr_pkg::ISO_BIT] :
                           miim_wr_hit[p] ? MIIM_WDATA_I[pscr_pkg::BMCR_ISO_BIT] :
                           iso_q[p];
         // no standard management bit for force link, register port only
         assign flink_d[p] = reg_wr_hit[p] ? REG_WDATA_I[pscr_pkg::FLINK_BIT] :
                             flink_q[p];
         // writing zero never aborts a reset, only a one starts one
         assign srst_start[p] = (reg_wr_hit[p] && REG_WDATA_I[pscr_pkg::SRST_BIT]) ||
                                (miim_wr_hit[p] && MIIM_WDATA_I[pscr_pkg::BMCR_RST_BIT]);

         // self-clearing reset pulse, bit reads one while it runs
         pscr_rst_timer u_rst (
            .CORE_CLK_I(CORE_CLK_I),
            .RESETN_I(RESETN_I),
            .start_i(srst_start[p]),
            .busy_o(srst_busy[p])
         );

         // forced at once, so a read in the first reset cycle already shows 001;
         // the captured copy alone would lag the busy bit by one cycle
         assign opm_view[p] = srst_busy[p] ? pscr_pkg::OPM_RST : opm_q[p];

         // operation mode capture; forced back to an-in-progress during reset
         always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
               opm_q[p] <= pscr_pkg::OPM_RST;
            end else if (srst_busy[p]) begin
               opm_q[p] <= pscr_pkg::OPM_RST;
            end else begin
               opm_q[p] <= stat[p].opmode;
            end
         end
      end
   endgenerate

   // control bits; bit 6 has no storage so writes to it vanish
   // one small vector per field keeps every write decode at most two muxes deep
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         loop_q <= 2'h0;
         iso_q <= 2'h0;
         flink_q <= 2'h0;
      end else begin
         loop_q <= loop_d;
         iso_q <= iso_d;
         flink_q <= flink_d;
      end
   end

   // =====================================================================
   // phy control outputs
   // =====================================================================
   assign PHY1_CTRL_O = '{loopback: loop_q[0], isolate: iso_q[0],
                          soft_reset: srst_busy[0], force_link: flink_q[0]};
   assign PHY2_CTRL_O = '{loopback: loop_q[1], isolate: iso_q[1],
                          soft_reset: srst_busy[1], force_link: flink_q[1]};
   // a looped port's frames enter and leave on the other phy port
   assign PHY1_MONITOR_O = 2'h2;
   assign PHY2_MONITOR_O = 2'h1;

   // =====================================================================
   // register port read mux
   // =====================================================================
   // views take the forced mode, so reset bit and mode never disagree on a read
   wire logic [7:0] view1 = stat2_view(loop_q[0], iso_q[0], srst_busy[0], flink_q[0], opm_view[0]);
   wire logic [7:0] view2 = stat2_view(loop_q[1], iso_q[1], srst_busy[1], flink_q[1], opm_view[1]);
   logic [7:0] rd_mux; // selected read value

   always_comb begin
      case (REG_ADDR_I)
         pscr_pkg::P1_STAT1_OFS: rd_mux = {3'h0, stat[0].partner};
         pscr_pkg::P2_STAT1_OFS: rd_mux = {3'h0, stat[1].partner};
         pscr_pkg::P1_STAT2_OFS: rd_mux = view1;
         pscr_pkg::P2_STAT2_OFS: rd_mux = view2;
         pscr_pkg::P3_STAT2_OFS: rd_mux = pscr_pkg::NOPHY_READ;
         pscr_pkg::P4_STAT2_OFS: rd_mux = pscr_pkg::NOPHY_READ;
         default: rd_mux = 8'h00; // unmapped reads as zero
      endcase
   end

   // registered read data, one cycle after the strobe
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         REG_RDATA_O <= 8'h00;
         REG_RVALID_O <= 1'b0;
      end else begin
         REG_RDATA_O <= REG_RD_I ? rd_mux : REG_RDATA_O;
         REG_RVALID_O <= REG_RD_I;
      end
   end

   // =====================================================================
   // management register read mux
   // =====================================================================
   wire logic mp = MIIM_PHY_I; // selected phy
   logic [15:0] mii_mux;

   always_comb begin
      mii_mux = 16'h0000;
      case (MIIM_REG_I)
         pscr_pkg::MII_BMCR: begin
            mii_mux[pscr_pkg::BMCR_RST_BIT] = srst_busy[mp];
            mii_mux[pscr_pkg::BMCR_LOOP_BIT] = loop_q[mp];
            mii_mux[pscr_pkg::BMCR_ISO_BIT] = iso_q[mp];
         end
         pscr_pkg::MII_BMSR: begin
            mii_mux[pscr_pkg::BMSR_LINK_BIT] = stat[mp].link_up || flink_q[mp];
            // same forced mode as the register port, both views stay in step
            mii_mux[pscr_pkg::BMSR_ANC_BIT] = (opm_view[mp] != pscr_pkg::OPM_RST);
         end
         pscr_pkg::MII_ANLPAR: begin
            mii_mux[pscr_pkg::ANLPAR_10HD_BIT +: 4] = stat[mp].partner[3:0];
            mii_mux[pscr_pkg::ANLPAR_PAUSE_BIT] = stat[mp].partner[4];
         end
         default: mii_mux = 16'h0000; // other numbers read zero
      endcase
   end

   // registered management read data
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         MIIM_RDATA_O <= 16'h0000;
         MIIM_RVALID_O <= 1'b0;
      end else begin
         MIIM_RDATA_O <= MIIM_RD_I ? mii_mux : MIIM_RDATA_O;
         MIIM_RVALID_O <= MIIM_RD_I;
      end
   end

   // =====================================================================
   // assertions
   // =====================================================================
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);

   a_partner_read: assert property (
      REG_RD_I && REG_ADDR_I == pscr_pkg::P1_STAT1_OFS |=>
         REG_RVALID_O && REG_RDATA_O == {3'h0, $past(PHY1_STAT_I.partner)})
      else $error("partner ability read wrong");

   a_loop_follows: assert property (
      REG_WR_I && REG_ADDR_I == pscr_pkg::P1_STAT2_OFS && !REG_WDATA_I[4] |=>
         PHY1_CTRL_O.loopback == $past(REG_WDATA_I[7]))
      else $error("loopback output does not follow write");

   // between writes the loop setting must not drift
   a_loop_hold: assert property (
      !reg_wr_hit[0] && !miim_wr_hit[0] |=> $stable(PHY1_CTRL_O.loopback))
      else $error("loopback output changed without a write");

   a_monitor_pair: assert property (
      PHY2_CTRL_O.loopback |-> PHY2_MONITOR_O == 2'h1 && PHY1_MONITOR_O == 2'h2)
      else $error("monitor port pairing wrong");

   a_isolate_write: assert property (
      REG_WR_I && REG_ADDR_I == pscr_pkg::P2_STAT2_OFS |=>
         PHY2_CTRL_O.isolate == $past(REG_WDATA_I[5]))
      else $error("isolate output does not follow write");

   // busy for exactly the pulse length: high for 20 samples, low on the 21st
   a_rst_selfclear: assert property (
      $rose(PHY1_CTRL_O.soft_reset) |-> ##19 PHY1_CTRL_O.soft_reset ##1
         !PHY1_CTRL_O.soft_reset)
      else $error("soft reset pulse length wrong");

   a_flink_write: assert property (
      REG_WR_I && REG_ADDR_I == pscr_pkg::P1_STAT2_OFS |=>
         PHY1_CTRL_O.force_link == $past(REG_WDATA_I[3]))
      else $error("force link output does not follow write");

   a_opmode_read: assert property (
      REG_RD_I && REG_ADDR_I == pscr_pkg::P2_STAT2_OFS && srst_busy[1] |=>
         REG_RDATA_O[2:0] == 3'b001)
      else $error("operation mode not an during reset");

   a_nophy_reserved: assert property (
      REG_RD_I && REG_ADDR_I == pscr_pkg::P3_STAT2_OFS |=> REG_RDATA_O[7:1] == 7'h00)
      else $error("port 3 reserved bits not zero");

   a_miim_isolate: assert property (
      MIIM_RD_I && MIIM_REG_I == pscr_pkg::MII_BMCR && !MIIM_PHY_I |=>
         MIIM_RDATA_O[10] == $past(PHY1_CTRL_O.isolate))
      else $error("management view of isolate wrong");

   a_rsv_bit6: assert property (
      REG_RD_I && REG_ADDR_I == pscr_pkg::P1_STAT2_OFS |=>
         !REG_RDATA_O[6] && REG_RDATA_O[4] == $past(PHY1_CTRL_O.soft_reset))
      else $error("bit 6 or reset bit readback wrong");

   // answer strobes are plain one-cycle echoes of the request strobes
   a_rvalid_pulse: assert property (
      REG_RVALID_O == $past(REG_RD_I))
      else $error("register read valid not one cycle after strobe");

   a_miim_rvalid: assert property (
      MIIM_RVALID_O == $past(MIIM_RD_I))
      else $error("management read valid not one cycle after strobe");

   a_miim_rst_start: assert property (
      miim_wr_hit[0] && MIIM_WDATA_I[pscr_pkg::BMCR_RST_BIT] && !PHY1_CTRL_O.soft_reset |=>
         PHY1_CTRL_O.soft_reset)
      else $error("management write did not start soft reset");

   a_iso_miim: assert property (
      miim_wr_hit[1] && !reg_wr_hit[1] |=>
         PHY2_CTRL_O.isolate == $past(MIIM_WDATA_I[pscr_pkg::BMCR_ISO_BIT]))
      else $error("management write did not set isolate");

   a_link_view: assert property (
      MIIM_RD_I && MIIM_REG_I == pscr_pkg::MII_BMSR && !MIIM_PHY_I |=>
         MIIM_RDATA_O[2] == $past(PHY1_STAT_I.link_up || PHY1_CTRL_O.force_link))
      else $error("management link view ignores force link");

   // main scenarios: reset pulse, port 2 loop, port 1 management write, mode capture, force link
   c_soft_reset: cover property ($fell(PHY1_CTRL_O.soft_reset));
   c_loop_p2: cover property ($rose(PHY2_CTRL_O.loopback));
   c_miim_write: cover property (miim_wr_hit[0]);
   c_mode_100fd: cover property (opm_q[0] == pscr_pkg::OPM_100FD);
   c_force_link: cover property ($rose(PHY1_CTRL_O.force_link));
endmodule : pscr_regs

// File: tb/pscr_regs_tb_top.sv
// self-checking bench for the port phy status/control register bank
module pscr_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // =====================================================================
   // clock, reset and design stimulus
   // =====================================================================
   logic core_clk = 1'b0; // 200 mhz core clock
   logic resetn = 1'b0; // active low reset
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic miim_phy = 1'b0;
   logic [4:0] miim_reg = 5'h00;
   logic miim_wr = 1'b0;
   logic miim_rd = 1'b0;
   logic [15:0] miim_wdata = 16'h0000;
   logic [15:0] miim_rdata;
   logic miim_rvalid;
   // phy status levels; a phy out of reset reports an-in-progress
   pscr_pkg::pscr_phy_stat_s phy1_stat = '{partner: 5'h00, opmode: 3'h1, link_up: 1'b0};
   pscr_pkg::pscr_phy_stat_s phy2_stat = '{partner: 5'h00, opmode: 3'h1, link_up: 1'b0};
   pscr_pkg::pscr_phy_ctrl_s phy1_ctrl;
   pscr_pkg::pscr_phy_ctrl_s phy2_ctrl;
   logic [1:0] phy1_mon;
   logic [1:0] phy2_mon;
   int mismatches = 0; // failed comparisons
   int compares = 0; // all comparisons
   int n; // cycle counter for bounded waits
   logic [7:0] rd8; // last register-port read
   logic [15:0] rd16; // last management read

   always #2.5 core_clk = ~core_clk;

   pscr_regs pscr_regs_inst (
      .CORE_CLK_I(core_clk), .RESETN_I(resetn), .REG_ADDR_I(reg_addr), .REG_WR_I(reg_wr),
      .REG_RD_I(reg_rd), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata),
      .REG_RVALID_O(reg_rvalid), .MIIM_PHY_I(miim_phy), .MIIM_REG_I(miim_reg),
      .MIIM_WR_I(miim_wr), .MIIM_RD_I(miim_rd), .MIIM_WDATA_I(miim_wdata),
      .MIIM_RDATA_O(miim_rdata), .MIIM_RVALID_O(miim_rvalid), .PHY1_STAT_I(phy1_stat),
      .PHY2_STAT_I(phy2_stat), .PHY1_CTRL_O(phy1_ctrl), .PHY2_CTRL_O(phy2_ctrl),
      .PHY1_MONITOR_O(phy1_mon), .PHY2_MONITOR_O(phy2_mon)
   );

   // =====================================================================
   // access and compare tasks; each starts and ends 1 ns after an edge
   // =====================================================================
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one idle edge first, so back-to-back calls never retoggle a strobe in one step
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      cycles(1);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge core_clk);
      #1 reg_wr = 1'b0;
   endtask : reg_write

   // read answer lands on the taken edge itself and is checked 1 ns later
   task automatic reg_read(input logic [7:0] a);
      cycles(1);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge core_clk);
      #1 reg_rd = 1'b0;
      check("reg rvalid", {15'h0000, reg_rvalid}, 16'h0001);
      rd8 = reg_rdata;
   endtask : reg_read

   task automatic miim_write(input logic p, input logic [4:0] r, input logic [15:0] d);
      cycles(1);
      miim_phy = p;
      miim_reg = r;
      miim_wdata = d;
      miim_wr = 1'b1;
      @(posedge core_clk);
      #1 miim_wr = 1'b0;
   endtask : miim_write

   task automatic miim_read(input logic p, input logic [4:0] r);
      cycles(1);
      miim_phy = p;
      miim_reg = r;
      miim_rd = 1'b1;
      @(posedge core_clk);
      #1 miim_rd = 1'b0;
      check("miim rvalid", {15'h0000, miim_rvalid}, 16'h0001);
      rd16 = miim_rdata;
   endtask : miim_read

   task automatic cycles(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : cycles

   // verdict and end of run, also reached by a timeout
   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   // =====================================================================
   // main sequence
   // =====================================================================
   initial begin
      repeat (6) @(posedge core_clk);
      #1 resetn = 1'b1;
      // reset values of both phy registers and the port 1 partner bits
      reg_read(pscr_pkg::P1_STAT2_OFS);
      check("p1 stat2 reset", {8'h00, rd8}, 16'h0001);
      reg_read(pscr_pkg::P2_STAT2_OFS);
      check("p2 stat2 reset", {8'h00, rd8}, 16'h0001);
      reg_read(pscr_pkg::P1_STAT1_OFS);
      check("p1 partner reset", {8'h00, rd8}, 16'h0000);
      check("ctrl reset", {8'h00, phy1_ctrl, phy2_ctrl}, 16'h0000);
      check("monitor ports", {12'h000, phy1_mon, phy2_mon}, 16'h0009);
      // partner bits are read-only and follow the phy
      phy1_stat.partner = 5'b10110;
      phy1_stat.opmode = 3'b110;
      reg_write(pscr_pkg::P1_STAT1_OFS, 8'h00);
      reg_read(pscr_pkg::P1_STAT1_OFS);
      check("p1 partner", {8'h00, rd8}, 16'h0016);
      // loop, reserved, isolate and force link set; reserved must stay clear
      reg_write(pscr_pkg::P1_STAT2_OFS, 8'hE8);
      check("p1 ctrl", {12'h000, phy1_ctrl}, 16'h000D);
      check("p2 ctrl untouched", {12'h000, phy2_ctrl}, 16'h0000);
      reg_read(pscr_pkg::P1_STAT2_OFS);
      check("p1 stat2", {8'h00, rd8}, 16'h00AE);
      // management view of the same port
      miim_read(1'b0, pscr_pkg::MII_BMCR);
      check("bmcr p1", rd16, 16'h4400);
      miim_read(1'b0, pscr_pkg::MII_BMSR);
      check("bmsr p1", rd16, 16'h0024);
      miim_read(1'b0, pscr_pkg::MII_ANLPAR);
      check("anlpar p1", rd16, 16'h04C0);
      // clearing restores normal operation
      reg_write(pscr_pkg::P1_STAT2_OFS, 8'h00);
      check("p1 ctrl clear", {12'h000, phy1_ctrl}, 16'h0000);
      miim_read(1'b0, pscr_pkg::MII_BMSR);
      check("bmsr no link", rd16, 16'h0020);
      // loopback of port 2 set from the management side
      miim_write(1'b1, pscr_pkg::MII_BMCR, 16'h4000);
      check("p2 loop via miim", {12'h000, phy2_ctrl}, 16'h0008);
      reg_read(pscr_pkg::P2_STAT2_OFS);
      check("p2 stat2 loop", {8'h00, rd8}, 16'h0081);
      // every operation mode code
      for (int i = 0; i < 5; i++) begin
         phy2_stat.opmode = (i == 0) ? 3'b001 : (i == 1) ? 3'b010 : (i == 2) ? 3'b011
            : (i == 3) ? 3'b101 : 3'b110;
         cycles(2);
         reg_read(pscr_pkg::P2_STAT2_OFS);
         check("p2 opmode", {8'h00, rd8}, {8'h00, 5'b10000, phy2_stat.opmode});
      end
      // soft reset: self clears after the pulse, opmode forced meanwhile
      reg_write(pscr_pkg::P2_STAT2_OFS, 8'h10);
      check("p2 srst start", {12'h000, phy2_ctrl}, 16'h0002);
      reg_read(pscr_pkg::P2_STAT2_OFS);
      check("p2 srst busy", {8'h00, rd8}, 16'h0011);
      n = 2; // edges since the write was taken; the busy read used two
      while (phy2_ctrl.soft_reset === 1'b1 && n < 100) begin
         cycles(1);
         n++;
      end
      if (n >= 100) begin
         mismatches++;
         results();
      end
      check("srst length", n[15:0], 16'(pscr_pkg::SRST_CYCLES));
      cycles(2);
      reg_read(pscr_pkg::P2_STAT2_OFS);
      check("p2 srst done", {8'h00, rd8}, 16'h0006);
      // management reset start on port 1 together with isolate
      miim_write(1'b0, pscr_pkg::MII_BMCR, 16'h8400);
      check("p1 miim srst", {12'h000, phy1_ctrl}, 16'h0006);
      cycles(pscr_pkg::SRST_CYCLES);
      miim_read(1'b0, pscr_pkg::MII_BMCR);
      check("bmcr p1 after srst", rd16, 16'h0400);
      // ports without phy ignore writes; unmapped places read zero
      reg_write(pscr_pkg::P3_STAT2_OFS, 8'hFF);
      reg_read(pscr_pkg::P3_STAT2_OFS);
      check("p3 reserved", {8'h00, rd8}, 16'h0001);
      reg_write(pscr_pkg::P4_STAT2_OFS, 8'hFE);
      reg_read(pscr_pkg::P4_STAT2_OFS);
      check("p4 reserved", {8'h00, rd8}, 16'h0001);
      reg_read(8'h00);
      check("unmapped", {8'h00, rd8}, 16'h0000);
      results();
   end

   // hang guard, far beyond the sequence length
   initial begin
      #20us;
      mismatches++;
      results();
   end
endmodule : pscr_regs_tb_top
